// ==== hdl/fews_seq.sv ====
// Flash erase and rotating-row write sequencer with APB register access
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module fews_seq
  import fews_pkg::*;
#(
  parameter int ARRAY_BYTES = 65536
)(
  input  wire logic        clock,      // bus clock, 10 MHz
  input  wire logic        rst_b,      // sync reset, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB direction
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic [31:0]      prdata_r,   // APB read data
  output logic             pready_r,   // APB ready
  output logic             pslverr_r,  // APB error on unmapped address
  input  wire logic        wait_mode,  // CPU in wait
  input  wire logic        stop_mode,  // CPU in stop
  input  wire logic [7:0]  flash_rdata,// array read data, same cycle as rd_en
  output fews_flash_cmd_s  flash_cmd_r,// array command bundle
  output logic             pump_en_r,  // charge pump enable
  output logic             standby_r,  // array low-power standby
  output logic             irq_mask_r, // maskable interrupts blocked
  output logic             busy_r      // operation in progress
);
  `include "fews_cfg.svh"
  localparam logic [15:0] ARRAY_MASK = 16'(ARRAY_BYTES - 1);

  fews_state_e     state_r;
  fews_flash_cmd_s cmd_nxt;
  logic [1:0]      size_r;
  logic [15:0]     addr_r, last_r, erase_delay_param_r, row_base_r, row_cnt_r, idx_r, tgt_idx_r;
  logic [7:0]      speed_r, maxpulse_r, pulses_r;
  logic [63:0]     data_r;
  logic [2:0]      byte_r;
  logic            is_write_r, success_r, stuck_r, ref_bit_r, tgt_bit_r, tgt_found_r;
  logic            tmr_start, tmr_done, lowpwr, apb_wr, apb_rd;
  fews_us_t        tmr_us;

  assign lowpwr = wait_mode | stop_mode;
  assign apb_wr = psel & penable & pready_r & pwrite;
  assign apb_rd = psel & penable & ~pready_r & ~pwrite;

  function automatic logic hit(input logic [7:0] a);
    hit = (a[1:0] == 2'h0) && (a <= `FEWS_OFF_STATUS);
  endfunction

  // Base of the block of the given size that holds the address
  function automatic logic [15:0] erase_base(input logic [15:0] a, input logic [1:0] sz);
    unique case (sz)
      `FEWS_SIZE_ARRAY: erase_base = a & ~ARRAY_MASK;
      `FEWS_SIZE_HALF:  erase_base = a & ~(ARRAY_MASK >> 1);
      `FEWS_SIZE_EIGHT: erase_base = a & ~16'(8 * `FEWS_ROW_BYTES - 1);
      `FEWS_SIZE_ROW:   erase_base = a & ~16'(`FEWS_ROW_BYTES - 1);
    endcase
  endfunction

  function automatic logic [7:0] byte_of(input logic [63:0] d, input logic [2:0] i);
    byte_of = d[{i, 3'h0} +: 8];
  endfunction

  // Timer: erase interval in 24 us units, program pulse fixed
  assign tmr_us = (state_r == FEWS_ERASE) ? fews_us_t'(erase_delay_param_r * `FEWS_ERASE_UNIT_US)
                                          : fews_us_t'(`FEWS_PULSE_US);
  assign tmr_start = (flash_cmd_r.high_voltage_enable == 1'b0) &&
                     (cmd_nxt.high_voltage_enable == 1'b1);

  fews_us_timer u_timer (
    .clock    (clock),
    .rst_b    (rst_b),
    .start    (tmr_start),
    .run      (pump_en_r),
    .speed    (speed_r),
    .us_count (tmr_us),
    .done_r   (tmr_done)
  );

  // APB answer: one wait state, then ready with data or error
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~hit(paddr);
      prdata_r  <= 32'h0;
      if (apb_rd && hit(paddr)) begin
        unique case (paddr)
          `FEWS_OFF_CTRL:     prdata_r <= {25'h0, size_r, 5'h0};
          `FEWS_OFF_ADDR:     prdata_r <= {16'h0, addr_r};
          `FEWS_OFF_LAST:     prdata_r <= {16'h0, last_r};
          `FEWS_OFF_SPEED:    prdata_r <= {24'h0, speed_r};
          `FEWS_OFF_ERASE_DELAY_PARAM:   prdata_r <= {16'h0, erase_delay_param_r};
          `FEWS_OFF_MAXPULSE: prdata_r <= {24'h0, maxpulse_r};
          `FEWS_OFF_DATA_LO:  prdata_r <= data_r[31:0];
          `FEWS_OFF_DATA_HI:  prdata_r <= data_r[63:32];
          default:            prdata_r <= {tgt_idx_r, 12'h0, stuck_r, irq_mask_r, success_r, busy_r};
        endcase
      end
    end
  end

  // Parameter registers; frozen while an operation runs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      size_r     <= `FEWS_SIZE_ARRAY;
      addr_r     <= 16'h0000;
      last_r     <= 16'h0000;
      speed_r    <= `FEWS_RST_SPEED;
      erase_delay_param_r   <= `FEWS_RST_ERASE_DELAY_PARAM;
      maxpulse_r <= `FEWS_RST_MAXPULSE;
    end else if (apb_wr && !busy_r) begin
      unique case (paddr)
        `FEWS_OFF_CTRL:     size_r     <= pwdata[`FEWS_CTRL_SIZE_HI:`FEWS_CTRL_SIZE_LO];
        `FEWS_OFF_ADDR:     addr_r     <= pwdata[15:0];
        `FEWS_OFF_LAST:     last_r     <= pwdata[15:0];
        `FEWS_OFF_SPEED:    speed_r    <= pwdata[7:0];
        `FEWS_OFF_ERASE_DELAY_PARAM:   erase_delay_param_r   <= pwdata[15:0];
        `FEWS_OFF_MAXPULSE: maxpulse_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Data buffer; the cycling bit is owned by the sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      data_r <= 64'h0;
    end else if (state_r == FEWS_SCAN_CHK && tgt_found_r) begin
      data_r[`FEWS_CYC_BIT] <= ~tgt_bit_r;
    end else if (apb_wr && !busy_r && paddr == `FEWS_OFF_DATA_LO) begin
      data_r[31:0] <= pwdata;
    end else if (apb_wr && !busy_r && paddr == `FEWS_OFF_DATA_HI) begin
      data_r[63:32] <= pwdata;
    end
  end

  // Flash command for the next cycle
  always_comb begin
    cmd_nxt = '0;
    unique case (state_r)
      FEWS_SCAN_REQ: begin
        cmd_nxt.rd_en = 1'b1;
        cmd_nxt.addr  = addr_r + 16'({idx_r, 3'h0});
      end
      FEWS_ERASE: begin
        cmd_nxt.erase_select        = 1'b1;
        cmd_nxt.high_voltage_enable = 1'b1;
        cmd_nxt.erase_size          = is_write_r ? `FEWS_SIZE_ROW : size_r;
        cmd_nxt.addr                = is_write_r ? row_base_r : erase_base(addr_r, size_r);
      end
      FEWS_PROG: begin
        cmd_nxt.program_select      = 1'b1;
        cmd_nxt.high_voltage_enable = 1'b1;
        cmd_nxt.addr                = row_base_r + 16'(byte_r);
        cmd_nxt.wdata               = byte_of(data_r, byte_r);
      end
      FEWS_VER_REQ: begin
        cmd_nxt.rd_en = 1'b1;
        cmd_nxt.addr  = row_base_r + 16'(byte_r);
        cmd_nxt.wdata = byte_of(data_r, byte_r);
      end
      default: ;
    endcase
    if (state_r != FEWS_IDLE && state_r != FEWS_SCAN_REQ && tmr_done) begin
      cmd_nxt.high_voltage_enable = 1'b0;
    end
  end

  // Flash pins; low power freezes the array in its current mode
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flash_cmd_r <= '0;
      pump_en_r   <= 1'b0;
      standby_r   <= 1'b0;
    end else begin
      if (!lowpwr && !stuck_r) begin
        flash_cmd_r <= cmd_nxt;
      end
      pump_en_r <= ~lowpwr & ~stuck_r;
      standby_r <= stop_mode & ~busy_r;
    end
  end

  // Low power during an operation needs a reset to leave
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stuck_r <= 1'b0;
    end else if (lowpwr && busy_r) begin
      stuck_r <= 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r     <= FEWS_IDLE;
      busy_r      <= 1'b0;
      is_write_r  <= 1'b0;
      success_r   <= 1'b0;
      irq_mask_r  <= 1'b1;
      row_base_r  <= 16'h0000;
      row_cnt_r   <= 16'h0000;
      idx_r       <= 16'h0000;
      tgt_idx_r   <= 16'h0000;
      ref_bit_r   <= 1'b0;
      tgt_bit_r   <= 1'b0;
      tgt_found_r <= 1'b0;
      byte_r      <= 3'h0;
      pulses_r    <= 8'h00;
    end else if (!lowpwr && !stuck_r) begin
      unique case (state_r)
        FEWS_IDLE: begin
          if (apb_wr && paddr == `FEWS_OFF_CTRL && pwdata[`FEWS_CTRL_IMCLR]) begin
            irq_mask_r <= 1'b0;
          end
          if (apb_wr && paddr == `FEWS_OFF_CTRL && pwdata[`FEWS_CTRL_ERASE]) begin
            busy_r     <= 1'b1;
            is_write_r <= 1'b0;
            state_r    <= FEWS_ERASE;
          end else if (apb_wr && paddr == `FEWS_OFF_CTRL && pwdata[`FEWS_CTRL_WRITE]) begin
            busy_r      <= 1'b1;
            is_write_r  <= 1'b1;
            row_cnt_r   <= (last_r - addr_r) >> 3;
            idx_r       <= 16'h0000;
            tgt_found_r <= 1'b0;
            state_r     <= FEWS_SCAN_REQ;
          end
        end
        FEWS_SCAN_REQ: state_r <= FEWS_SCAN_CHK;
        FEWS_SCAN_CHK: begin
          if (tgt_found_r) begin
            row_base_r <= addr_r + 16'({tgt_idx_r, 3'h0});
            state_r    <= FEWS_ERASE;
          end else if (idx_r == 16'h0000) begin
            ref_bit_r <= flash_rdata[`FEWS_CYC_BIT];
            tgt_bit_r <= flash_rdata[`FEWS_CYC_BIT];
            tgt_idx_r <= 16'h0000;
            if (row_cnt_r == 16'h0000) begin
              tgt_found_r <= 1'b1;
            end else begin
              idx_r   <= 16'h0001;
              state_r <= FEWS_SCAN_REQ;
            end
          end else if (flash_rdata[`FEWS_CYC_BIT] != ref_bit_r) begin
            tgt_idx_r   <= idx_r;
            tgt_bit_r   <= flash_rdata[`FEWS_CYC_BIT];
            tgt_found_r <= 1'b1;
          end else if (idx_r == row_cnt_r) begin
            tgt_found_r <= 1'b1;
          end else begin
            idx_r   <= idx_r + 16'h0001;
            state_r <= FEWS_SCAN_REQ;
          end
        end
        FEWS_ERASE: begin
          if (tmr_done) begin
            byte_r   <= 3'h0;
            pulses_r <= 8'h00;
            if (is_write_r) begin
              state_r <= FEWS_PROG;
            end else begin
              success_r  <= 1'b1;
              irq_mask_r <= 1'b1;
              busy_r     <= 1'b0;
              state_r    <= FEWS_IDLE;
            end
          end
        end
        FEWS_PROG: begin
          if (tmr_done) begin
            pulses_r <= pulses_r + 8'h01;
            state_r  <= FEWS_VER_REQ;
          end
        end
        FEWS_VER_REQ: state_r <= FEWS_VER_CHK;
        FEWS_VER_CHK: begin
          if (flash_rdata == flash_cmd_r.wdata && byte_r == 3'h7) begin
            success_r  <= 1'b1;
            irq_mask_r <= 1'b1;
            busy_r     <= 1'b0;
            state_r    <= FEWS_IDLE;
          end else if (flash_rdata == flash_cmd_r.wdata) begin
            byte_r   <= byte_r + 3'h1;
            pulses_r <= 8'h00;
            state_r  <= FEWS_PROG;
          end else if (pulses_r >= maxpulse_r) begin
            success_r  <= 1'b0;
            irq_mask_r <= 1'b1;
            busy_r     <= 1'b0;
            state_r    <= FEWS_IDLE;
          end else begin
            state_r <= FEWS_PROG;
          end
        end
        default: state_r <= FEWS_IDLE;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_erase_size;
    (state_r == FEWS_ERASE && !is_write_r && flash_cmd_r.erase_select) |-> flash_cmd_r.erase_size == size_r;
  endproperty
  a_erase_size: assert property (p_erase_size) else $error("erase size differs from code");

  property p_erase_base;
    (flash_cmd_r.erase_select && !is_write_r) |-> (flash_cmd_r.addr == erase_base(addr_r, size_r));
  endproperty
  a_erase_base: assert property (p_erase_base) else $error("erase base not aligned block");

  property p_addr_kept;
    busy_r |=> $stable(addr_r);
  endproperty
  a_addr_kept: assert property (p_addr_kept) else $error("address changed during operation");

  property p_mask_on_exit;
    $fell(busy_r) |-> irq_mask_r;
  endproperty
  a_mask_on_exit: assert property (p_mask_on_exit) else $error("mask clear at completion");

  property p_rows;
    (state_r == FEWS_SCAN_CHK) |-> (row_cnt_r == (last_r - addr_r) >> 3) && (idx_r <= row_cnt_r);
  endproperty
  a_rows: assert property (p_rows) else $error("row scan out of ring");

  property p_cyc_bit;
    (flash_cmd_r.program_select && flash_cmd_r.addr == row_base_r)
      |-> flash_cmd_r.wdata[`FEWS_CYC_BIT] == ~tgt_bit_r;
  endproperty
  a_cyc_bit: assert property (p_cyc_bit) else $error("cycling bit not inverted");

  property p_fail;
    (state_r == FEWS_VER_CHK && flash_rdata != flash_cmd_r.wdata && pulses_r >= maxpulse_r && !lowpwr && !stuck_r)
      |=> !success_r && !busy_r;
  endproperty
  a_fail: assert property (p_fail) else $error("no failure after pulse limit");

  property p_pump_off;
    lowpwr |=> !pump_en_r;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump on in low power");

  property p_hold;
    (stuck_r && $past(stuck_r)) |-> $stable(flash_cmd_r) ##1 $stable(flash_cmd_r);
  endproperty
  a_hold: assert property (p_hold) else $error("flash mode moved in low power");

  property p_stuck;
    stuck_r |=> stuck_r [*4];
  endproperty
  a_stuck: assert property (p_stuck) else $error("low-power lock released without reset");

  property p_standby;
    (stop_mode && !busy_r) |=> standby_r;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby in stop");

  c_erase: cover property ($fell(busy_r) && !is_write_r);
  c_write_ok: cover property ($fell(busy_r) && is_write_r && success_r);
  c_write_fail: cover property ($fell(busy_r) && is_write_r && !success_r);
  c_later_row: cover property (state_r == FEWS_ERASE && is_write_r && tgt_idx_r != 16'h0000);
endmodule

// ==== hdl/fews_cfg.svh ====
// Offsets, field positions, reset values and timing figures of the flash sequencer
`ifndef FEWS_CFG_SVH
`define FEWS_CFG_SVH
`define FEWS_OFF_CTRL      8'h00
`define FEWS_OFF_ADDR      8'h04
`define FEWS_OFF_LAST      8'h08
`define FEWS_OFF_SPEED     8'h0C
`define FEWS_OFF_ERASE_DELAY_PARAM    8'h10
`define FEWS_OFF_MAXPULSE  8'h14
`define FEWS_OFF_DATA_LO   8'h18
`define FEWS_OFF_DATA_HI   8'h1C
`define FEWS_OFF_STATUS    8'h20
`define FEWS_CTRL_ERASE    0
`define FEWS_CTRL_WRITE    1
`define FEWS_CTRL_IMCLR    2
`define FEWS_CTRL_SIZE_LO  5
`define FEWS_CTRL_SIZE_HI  6
`define FEWS_CYC_BIT       7
`define FEWS_SIZE_ARRAY    2'h0
`define FEWS_SIZE_HALF     2'h1
`define FEWS_SIZE_EIGHT    2'h2
`define FEWS_SIZE_ROW      2'h3
`define FEWS_ROW_BYTES     8
`define FEWS_ERASE_UNIT_US 24
`define FEWS_SPEED_DIV     4
`define FEWS_PULSE_US      10
`define FEWS_RST_SPEED     8'h28
`define FEWS_RST_ERASE_DELAY_PARAM    16'h0000
`define FEWS_RST_MAXPULSE  8'h0A
`endif

// ==== hdl/fews_pkg.sv ====
// Types shared by the flash sequencer files
package fews_pkg;
  typedef enum logic [2:0] {
    FEWS_IDLE, FEWS_SCAN_REQ, FEWS_SCAN_CHK, FEWS_ERASE, FEWS_PROG, FEWS_VER_REQ, FEWS_VER_CHK
  } fews_state_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd_en;
    logic        program_select;
    logic        erase_select;
    logic        high_voltage_enable;
    logic [1:0]  erase_size;
  } fews_flash_cmd_s;
  typedef logic [20:0] fews_us_t;
endpackage

// ==== hdl/fews_us_timer.sv ====
// Microsecond interval timer paced by the caller's speed figure
`timescale 1ns/10ps
module fews_us_timer
  import fews_pkg::*;
(
  input  wire logic       clock,    // bus clock
  input  wire logic       rst_b,    // sync reset, active low
  input  wire logic       start,    // load pulse
  input  wire logic       run,      // pump on; count advances
  input  wire logic [7:0] speed,    // MHz times four
  input  wire fews_us_t   us_count, // interval in microseconds
  output logic            done_r    // one-cycle end pulse
);
  `include "fews_cfg.svh"
  logic [5:0] pre_r;
  fews_us_t   us_r;
  logic       act_r;
  logic [5:0] cyc_per_us;

  // Zero or tiny speed still gives one cycle per microsecond
  always_comb begin
    cyc_per_us = speed[7:2];
    if (cyc_per_us == 6'h00) begin
      cyc_per_us = 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pre_r  <= 6'h00;
      us_r   <= '0;
      act_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        act_r <= 1'b1;
        // Load edge is the first cycle of the interval, so start one count short
        if (cyc_per_us != 6'h01) begin
          pre_r <= cyc_per_us - 6'h02;
          us_r  <= (us_count == '0) ? fews_us_t'(1) : us_count;
        end else begin
          pre_r <= 6'h00;
          us_r  <= (us_count > fews_us_t'(1)) ? us_count - fews_us_t'(1) : fews_us_t'(1);
        end
      end else if (act_r && run) begin
        if (pre_r != 6'h00) begin
          pre_r <= pre_r - 6'h01;
        end else if (us_r == fews_us_t'(1)) begin
          act_r  <= 1'b0;
          done_r <= 1'b1;
        end else begin
          us_r  <= us_r - fews_us_t'(1);
          pre_r <= cyc_per_us - 6'h01;
        end
      end
    end
  end
endmodule

// ==== verification/fews_flash_model.sv ====
// Flash array model: byte memory, pump-gated erase and program, combinational read
`timescale 1ns/10ps
module fews_flash_model
  import fews_pkg::*;
(
  input  wire logic            clock, // bus clock
  input  wire fews_flash_cmd_s cmd,   // command bundle
  input  wire logic            pump,  // charge pump enable
  input  wire logic            stuck, // cells refuse programming
  output logic [7:0]           rdata  // read data, same cycle as rd_en
);
  logic [7:0] mem [0:65535];
  logic       ers_done;
  int         sz;
  int         b;
  initial begin
    ers_done = 1'b0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
  end
  // Sequencer samples at the end of the cycle that shows rd_en
  // Idle cycles show the inverse, never stale data
  assign rdata = cmd.rd_en ? mem[cmd.addr] : ~mem[cmd.addr];
  always @(posedge clock) begin
    sz = (cmd.erase_size == 2'h0) ? 65536 : (cmd.erase_size == 2'h1) ? 32768 : (cmd.erase_size == 2'h2) ? 64 : 8;
    b = int'(cmd.addr) & ~(sz - 1);
    // Erase lands once per assertion, only with the pump on
    if (cmd.erase_select && cmd.high_voltage_enable && pump && !ers_done) begin
      for (int i = 0; i < sz; i++) mem[b + i] = 8'hFF;
      ers_done = 1'b1;
    end
    if (!cmd.erase_select) ers_done = 1'b0;
    // Stuck cells force the pulse limit
    if (cmd.program_select && cmd.high_voltage_enable && pump && !stuck) mem[cmd.addr] &= cmd.wdata;
  end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the flash sequencer
`timescale 1ns/10ps
`include "fews_cfg.svh"
module tb
  import fews_pkg::*;
;
  logic            clock, rst_b, psel, penable, pwrite, wait_mode, stop_mode, stuck;
  logic [7:0]      paddr, flash_rdata;
  logic [31:0]     pwdata, prdata_r, seed, q, lo;
  logic            pready_r, pslverr_r, pump_en_r, standby_r, irq_mask_r, busy_r, e, old;
  fews_flash_cmd_s flash_cmd_r;
  int              errors, n_tests, cyc, hv_n, pulse_n, sz, t, n;
  logic [15:0]     ers_a, base;
  logic [63:0]     dat;
  logic [7:0]      ref_m [0:23];

  fews_seq i_fews_seq (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .flash_rdata(flash_rdata), .flash_cmd_r(flash_cmd_r),
    .pump_en_r(pump_en_r), .standby_r(standby_r), .irq_mask_r(irq_mask_r), .busy_r(busy_r));
  fews_flash_model i_fews_flash_model (.clock(clock), .cmd(flash_cmd_r), .pump(pump_en_r), .stuck(stuck),
    .rdata(flash_rdata));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Holds the request until pready; one idle edge after keeps drivers single-assigned
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready_r !== 1'b1);
    q = prdata_r;
    e = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic run_op(input logic [1:0] s, input int st);
    logic pp;
    hv_n = 0;
    pulse_n = 0;
    pp = 1'b0;
    n = 0;
    apb(1'b1, `FEWS_OFF_CTRL, {25'h0, s, 5'h04});
    chk("irq_clear", irq_mask_r, 0);
    apb(1'b1, `FEWS_OFF_CTRL, {25'h0, s, 5'h00} | (32'h1 << st));
    while (busy_r === 1'b1 && n < 5000) begin
      @(posedge clock);
      n++;
      if (flash_cmd_r.erase_select && flash_cmd_r.high_voltage_enable) begin
        hv_n++;
        ers_a = flash_cmd_r.addr;
      end
      if (flash_cmd_r.program_select && !pp) pulse_n++;
      pp = flash_cmd_r.program_select;
    end
    chk("busy_end", busy_r, 0);
    chk("irq_exit", irq_mask_r, 1);
  endtask
  task automatic probe(input bit set);
    int a;
    for (int p = 0; p < 4; p++) begin
      a = int'(base) + ((p == 0) ? -1 : (p == 1) ? 0 : (p == 2) ? sz - 1 : sz);
      if (a >= 0 && a < 65536 && set) i_fews_flash_model.mem[a] = 8'h00;
      else if (a >= 0 && a < 65536) chk("erase_edge", i_fews_flash_model.mem[a], (p == 1 || p == 2) ? 8'hFF : 8'h00);
    end
  endtask

  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, wait_mode, stop_mode, stuck} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h763F;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("irq_reset", irq_mask_r, 1);
    apb(1'b0, `FEWS_OFF_SPEED, 32'h0);
    chk("speed_reset", q, 32'h28);
    apb(1'b0, `FEWS_OFF_MAXPULSE, 32'h0);
    chk("pulse_reset", q, 32'h0A);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", e, 1);
    apb(1'b1, `FEWS_OFF_SPEED, 32'h08);
    apb(1'b1, `FEWS_OFF_ERASE_DELAY_PARAM, 32'h02);
    for (int k = 0; k < 4; k++) begin
      sz = (k == 0) ? 65536 : (k == 1) ? 32768 : (k == 2) ? 64 : 8;
      seed = lfsr(seed);
      base = seed[15:0] & 16'(~(sz - 1));
      probe(1'b1);
      apb(1'b1, `FEWS_OFF_ADDR, {16'h0, seed[15:0]});
      run_op(2'(k), `FEWS_CTRL_ERASE);
      probe(1'b0);
      chk("erase_base", ers_a, base);
      chk("erase_time", hv_n, 24 * 2 * 2);
      apb(1'b0, `FEWS_OFF_ADDR, 32'h0);
      chk("addr_kept", q, {16'h0, seed[15:0]});
    end
    apb(1'b1, `FEWS_OFF_SPEED, 32'h04);
    apb(1'b1, `FEWS_OFF_ERASE_DELAY_PARAM, 32'h01);
    apb(1'b1, `FEWS_OFF_ADDR, 32'h7800);
    apb(1'b1, `FEWS_OFF_LAST, 32'h7810);
    for (int j = 0; j < 24; j++) begin
      i_fews_flash_model.mem[16'h7800 + j] = 8'hFF;
      ref_m[j] = 8'hFF;
    end
    for (int w = 0; w < 7; w++) begin
      seed = lfsr(seed);
      lo = seed;
      seed = lfsr(seed);
      dat = {seed, lo};
      apb(1'b1, `FEWS_OFF_DATA_LO, lo);
      apb(1'b1, `FEWS_OFF_DATA_HI, seed);
      t = 0;
      for (int r = 2; r >= 1; r--) if (ref_m[r * 8][7] != ref_m[0][7]) t = r;
      old = ref_m[t * 8][7];
      for (int j = 0; j < 8; j++) ref_m[t * 8 + j] = dat[j * 8 +: 8];
      ref_m[t * 8][7] = ~old;
      run_op(2'h3, `FEWS_CTRL_WRITE);
      apb(1'b0, `FEWS_OFF_STATUS, 32'h0);
      chk("row_pick", q[31:16], t);
      chk("ring_order", q[31:16], w % 3);
      chk("success", q[1], 1);
      for (int j = 0; j < 24; j++) chk("ring_byte", i_fews_flash_model.mem[16'h7800 + j], ref_m[j]);
    end
    stuck <= 1'b1;
    apb(1'b1, `FEWS_OFF_DATA_LO, 32'h0); // Byte zero can never match erased cells
    apb(1'b1, `FEWS_OFF_MAXPULSE, 32'h03);
    run_op(2'h3, `FEWS_CTRL_WRITE);
    chk("pulse_limit", pulse_n, 3);
    apb(1'b0, `FEWS_OFF_STATUS, 32'h0);
    chk("failure", q[1], 0);
    stuck <= 1'b0;
    apb(1'b1, `FEWS_OFF_CTRL, 32'h60);
    apb(1'b1, `FEWS_OFF_CTRL, 32'h61);
    n = 0;
    while (!(flash_cmd_r.erase_select && flash_cmd_r.high_voltage_enable) && n < 100) begin
      @(posedge clock);
      n++;
    end
    wait_mode <= 1'b1;
    repeat (40) @(posedge clock);
    chk("pump_wait", pump_en_r, 0);
    chk("mode_held", {flash_cmd_r.erase_select, flash_cmd_r.high_voltage_enable}, 2'h3);
    chk("busy_wait", busy_r, 1);
    wait_mode <= 1'b0;
    repeat (3) @(posedge clock);
    apb(1'b0, `FEWS_OFF_STATUS, 32'h0);
    chk("lock", q[3], 1);
    chk("pump_lock", pump_en_r, 0);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    apb(1'b0, `FEWS_OFF_STATUS, 32'h0);
    chk("unlock", q[3:2], 2'h1);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk("standby", standby_r, 1);
    chk("pump_stop", pump_en_r, 0);
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk("wait_idle", {standby_r, busy_r}, 2'h0);
    wait_mode <= 1'b0;
    wrap_up();
  end
endmodule
